// [mbfe_cfg.svh]
`ifndef MBFE_CFG_SVH
`define MBFE_CFG_SVH

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define MBFE_PORT_W 8
`define MBFE_ADDR_W 16
`define MBFE_CTRL_W 3
`define MBFE_SYNC_DEPTH 2
// Control strobes other than E clock idle high, so the control synchroniser starts out inactive unless the second input is set to E clock
`define MBFE_CTRL_IDLE 3'h7
`define MBFE_BYTE_RST 8'h00
`define MBFE_ADDR_RST 16'h0000

// ----------------------------------------
// Control input bit positions
// ----------------------------------------
`define MBFE_C0_BIT 0
`define MBFE_C1_BIT 1
`define MBFE_C2_BIT 2

`endif

// [mbfe_pkg.sv]
package mbfe_pkg;

  // ----------------------------------------
  // Build-time bus style choices
  // ----------------------------------------
  typedef enum logic [1:0] {
    MBFE_STYLE_MUX = 2'b00,
    MBFE_STYLE_NONMUX = 2'b01,
    MBFE_STYLE_PAGE = 2'b10,
    MBFE_STYLE_BURST = 2'b11
  } mbfe_style_e;

  typedef enum logic {
    MBFE_C0_WRITE_N = 1'b0,
    MBFE_C0_READ_WRITE_N = 1'b1
  } mbfe_c0_mode_e;

  typedef enum logic [1:0] {
    MBFE_C1_READ_N = 2'b00,
    MBFE_C1_DATA_STROBE_N = 2'b01,
    MBFE_C1_E_CLOCK = 2'b10,
    MBFE_C1_FETCH_READ_N = 2'b11
  } mbfe_c1_mode_e;

  typedef enum logic {
    MBFE_C2_FETCH_N = 1'b0,
    MBFE_C2_GENERIC = 1'b1
  } mbfe_c2_mode_e;

  // ----------------------------------------
  // Decoded controls handed to the decode logic
  // ----------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic code_fetch;
    logic generic_in;
    logic [2:0] raw;
  } mbfe_ctrl_s;

endpackage

// [mbfe_front_end.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mbfe_cfg.svh"

// Operation
// R1: Address strobe captures address, held after
// R2: Drive data only on selected read
// R3: Received address passed to decode logic
// R4: Multiplexed AD0-AD7 go on lower port
// R5: Non-multiplexed or page A0-A7 on lower
// R6: A8-A15 go on upper port
// R7: Page mode AD8-AD15 on upper port
// R8: Burst A4/D0-A11/D7 on lower port
// R9: Burst A12/D8-A19/D15 on upper port
// R10: Write strobe low means write request
// R11: Direction high read, low write
// R12: Read strobe low means read request
// R13: Second input takes data strobe/E clock
// R14: Second input takes fetch strobe read
// R15: Third input takes code fetch strobe
// R16: Third input otherwise generic logic input
// R17: All control inputs reach decode logic
// R18: Build-time setting selects bus style
module mbfe_front_end
  import mbfe_pkg::*;
#(
  parameter mbfe_style_e STYLE = MBFE_STYLE_MUX,
  parameter mbfe_c0_mode_e C0_MODE = MBFE_C0_WRITE_N,
  parameter mbfe_c1_mode_e C1_MODE = MBFE_C1_READ_N,
  parameter mbfe_c2_mode_e C2_MODE = MBFE_C2_FETCH_N
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [`MBFE_PORT_W-1:0] i_lower_addr_data_port,
  input wire logic [`MBFE_PORT_W-1:0] i_upper_addr_data_port,
  input wire logic i_address_strobe,
  input wire logic i_control_input_0,
  input wire logic i_control_input_1,
  input wire logic i_control_input_2,
  input wire logic i_block_select,
  input wire logic [2*`MBFE_PORT_W-1:0] i_read_data,
  output logic [`MBFE_PORT_W-1:0] o_lower_addr_data_port,
  output logic o_lower_addr_data_oe,
  output logic [`MBFE_PORT_W-1:0] o_upper_addr_data_port,
  output logic o_upper_addr_data_oe,
  output logic [`MBFE_ADDR_W-1:0] o_latched_addr,
  output mbfe_ctrl_s o_pld_ctrl
);

  // ----------------------------------------
  // Style decode
  // ----------------------------------------
  function automatic logic port_is_latched(input mbfe_style_e s, input logic upper);
    port_is_latched = upper ? (s == MBFE_STYLE_PAGE || s == MBFE_STYLE_BURST)
                            : (s == MBFE_STYLE_MUX || s == MBFE_STYLE_BURST);
  endfunction

  wire lower_latched = port_is_latched(STYLE, 1'b0); // [R18] [R4] [R8]
  wire upper_latched = port_is_latched(STYLE, 1'b1); // [R18] [R7] [R9]
  // Plain address styles never turn their lanes around
  wire lower_carries_data = (STYLE == MBFE_STYLE_MUX) || (STYLE == MBFE_STYLE_BURST); // [R5]
  wire upper_carries_data = (STYLE == MBFE_STYLE_PAGE) || (STYLE == MBFE_STYLE_BURST); // [R6]

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [`MBFE_PORT_W-1:0] lower_m_reg, lower_s_reg, upper_m_reg, upper_s_reg;
  logic [`MBFE_CTRL_W-1:0] ctrl_m_reg, ctrl_s_reg;
  logic as_m_reg, as_s_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lower_m_reg <= `MBFE_BYTE_RST;
      lower_s_reg <= `MBFE_BYTE_RST;
      upper_m_reg <= `MBFE_BYTE_RST;
      upper_s_reg <= `MBFE_BYTE_RST;
      ctrl_m_reg <= `MBFE_CTRL_IDLE;
      ctrl_s_reg <= `MBFE_CTRL_IDLE;
      as_m_reg <= 1'b0;
      as_s_reg <= 1'b0;
    end else begin
      lower_m_reg <= i_lower_addr_data_port;
      lower_s_reg <= lower_m_reg;
      upper_m_reg <= i_upper_addr_data_port;
      upper_s_reg <= upper_m_reg;
      ctrl_m_reg <= {i_control_input_2, i_control_input_1, i_control_input_0};
      ctrl_s_reg <= ctrl_m_reg;
      as_m_reg <= i_address_strobe;
      as_s_reg <= as_m_reg;
    end
  end

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  wire c0 = ctrl_s_reg[`MBFE_C0_BIT];
  wire c1 = ctrl_s_reg[`MBFE_C1_BIT];
  wire c2 = ctrl_s_reg[`MBFE_C2_BIT];
  // E clock is the only high-active strobe on the control inputs
  wire c1_active = (C1_MODE == MBFE_C1_E_CLOCK) ? c1 : ~c1; // [R12] [R13] [R14]
  wire dir_mode = (C0_MODE == MBFE_C0_READ_WRITE_N);
  wire rd_req = dir_mode ? (c0 & c1_active) : c1_active; // [R11] [R12]
  wire wr_req = dir_mode ? (~c0 & c1_active) : ~c0; // [R10] [R11]
  wire fetch_req = (C2_MODE == MBFE_C2_FETCH_N) & ~c2; // [R15]
  wire generic_in = (C2_MODE == MBFE_C2_GENERIC) & c2; // [R16]
  wire any_read = rd_req | fetch_req;

  // Drivers stay off while the strobe is up: the lanes carry address then
  wire drive_ok = any_read & i_block_select & ~as_s_reg & ~wr_req; // [R2]
  wire lower_oe_next = drive_ok & lower_carries_data;
  wire upper_oe_next = drive_ok & upper_carries_data;

  // ----------------------------------------
  // Address capture
  // ----------------------------------------
  // Latched lanes follow the pins while the strobe is up and freeze after
  wire [`MBFE_PORT_W-1:0] lower_addr_next =
      (lower_latched & ~as_s_reg) ? o_latched_addr[`MBFE_PORT_W-1:0] : lower_s_reg; // [R1]
  wire [`MBFE_PORT_W-1:0] upper_addr_next =
      (upper_latched & ~as_s_reg) ? o_latched_addr[`MBFE_ADDR_W-1:`MBFE_PORT_W]
                                  : upper_s_reg; // [R1]
  wire [`MBFE_PORT_W-1:0] upper_data_next = (STYLE == MBFE_STYLE_BURST) ?
      i_read_data[2*`MBFE_PORT_W-1:`MBFE_PORT_W] : i_read_data[`MBFE_PORT_W-1:0];

  mbfe_ctrl_s ctrl_next;
  assign ctrl_next = '{read: any_read, write: wr_req, code_fetch: fetch_req,
                       generic_in: generic_in, raw: ctrl_s_reg}; // [R17]

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_latched_addr <= `MBFE_ADDR_RST;
      o_pld_ctrl <= '{read: 1'b0, write: 1'b0, code_fetch: 1'b0, generic_in: 1'b0,
                      raw: `MBFE_CTRL_IDLE};
      o_lower_addr_data_oe <= 1'b0;
      o_upper_addr_data_oe <= 1'b0;
      o_lower_addr_data_port <= `MBFE_BYTE_RST;
      o_upper_addr_data_port <= `MBFE_BYTE_RST;
    end else begin
      o_latched_addr <= {upper_addr_next, lower_addr_next}; // [R3]
      o_pld_ctrl <= ctrl_next; // [R17]
      o_lower_addr_data_oe <= lower_oe_next; // [R2]
      o_upper_addr_data_oe <= upper_oe_next; // [R2]
      o_lower_addr_data_port <= i_read_data[`MBFE_PORT_W-1:0];
      o_upper_addr_data_port <= upper_data_next;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  addr_hold_a: assert property ( // [R1]
    (!as_s_reg && lower_latched) |=> $stable(o_latched_addr[`MBFE_PORT_W-1:0]))
    else $error("Latched lower address moved without strobe");

  addr_capture_a: assert property ( // [R1]
    as_s_reg |=> o_latched_addr[`MBFE_PORT_W-1:0] == $past(lower_s_reg))
    else $error("Address not captured under strobe");

  addr_track_a: assert property ( // [R3]
    !upper_latched |=> o_latched_addr[`MBFE_ADDR_W-1:`MBFE_PORT_W] == $past(upper_s_reg))
    else $error("Upper address not passed to decode");

  read_drive_a: assert property ( // [R2]
    (o_lower_addr_data_oe || o_upper_addr_data_oe) |->
      $past(i_block_select) && $past(any_read) && !$past(as_s_reg))
    else $error("Port driven outside a selected read");

  pin_to_oe_a: assert property ( // [R2]
    (i_control_input_0 == 1'b0 && C0_MODE == MBFE_C0_WRITE_N) [*4] |->
      !o_lower_addr_data_oe && !o_upper_addr_data_oe)
    else $error("Port driven during write");

  write_level_a: assert property ( // [R10]
    (C0_MODE == MBFE_C0_WRITE_N && !c0) |=> o_pld_ctrl.write)
    else $error("Low write strobe not seen as write");

  direction_a: assert property ( // [R11]
    (dir_mode && c1_active) |=> (o_pld_ctrl.read == $past(c0)) && (o_pld_ctrl.write != $past(c0)))
    else $error("Direction line misread");

  read_level_a: assert property ( // [R12]
    (C1_MODE == MBFE_C1_READ_N && !dir_mode && !c1) |=> o_pld_ctrl.read)
    else $error("Low read strobe not seen as read");

  fetch_level_a: assert property ( // [R15]
    (C2_MODE == MBFE_C2_FETCH_N && !c2) |=> o_pld_ctrl.code_fetch && o_pld_ctrl.read)
    else $error("Fetch strobe not seen");

  generic_pass_a: assert property ( // [R16]
    (C2_MODE == MBFE_C2_GENERIC) |=> o_pld_ctrl.generic_in == $past(c2) && !o_pld_ctrl.code_fetch)
    else $error("Generic input not passed through");

  fetch_read_a: assert property ( // [R14]
    (C1_MODE == MBFE_C1_FETCH_READ_N && !dir_mode && !c1) |=> o_pld_ctrl.read)
    else $error("Fetch strobe not taken as read");

  strobe_dir_a: assert property ( // [R13]
    (C1_MODE == MBFE_C1_DATA_STROBE_N && dir_mode && !c1) |=> o_pld_ctrl.read == $past(c0))
    else $error("Data strobe read not seen");

  write_quiet_a: assert property ( // [R2]
    (o_lower_addr_data_oe || o_upper_addr_data_oe) |-> !$past(wr_req))
    else $error("Port driven while write active");

  // Pins reach decode three edges late; reset-time pin levels are not checked
  raw_pass_a: assert property ( // [R17]
    $past(i_rst_n, 3) |-> o_pld_ctrl.raw == {$past(i_control_input_2, 3),
      $past(i_control_input_1, 3), $past(i_control_input_0, 3)})
    else $error("Control pins not passed to decode");

  read_cycle_c: cover property (as_s_reg ##1 !as_s_reg ##[1:8] o_lower_addr_data_oe);
  burst_read_c: cover property (o_lower_addr_data_oe && o_upper_addr_data_oe);
  write_cycle_c: cover property (as_s_reg ##1 !as_s_reg ##[1:8] o_pld_ctrl.write);
  fetch_cycle_c: cover property (o_pld_ctrl.code_fetch && o_pld_ctrl.read);

endmodule // mbfe_front_end

`default_nettype wire

// [mbfe_mcu_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// 8-bit bus master model
// ----------------------------------------
// Burst callers pass bus bits 19:4 as the address, so each lane carries 8 bits
module mbfe_mcu_model
  import mbfe_pkg::*;
#(
  parameter mbfe_style_e STYLE = MBFE_STYLE_MUX
) (
  input wire logic i_sys_clk,
  output logic [7:0] o_lower,
  output logic [7:0] o_upper,
  output logic o_strobe,
  output logic o_c0,
  output logic o_c1,
  output logic o_c2
);
  // Lanes that turn to data after the address phase
  localparam logic LOWER_SHARED = (STYLE == MBFE_STYLE_MUX) || (STYLE == MBFE_STYLE_BURST);
  localparam logic UPPER_SHARED = (STYLE == MBFE_STYLE_PAGE) || (STYLE == MBFE_STYLE_BURST);

  initial begin
    o_lower = 8'h00;
    o_upper = 8'h00;
    o_strobe = 1'b0;
    o_c0 = 1'b1;
    o_c1 = 1'b1;
    o_c2 = 1'b1;
  end

  task automatic addr_phase(input logic [15:0] addr);
    @(posedge i_sys_clk);
    o_lower <= addr[7:0];
    o_upper <= addr[15:8];
    o_strobe <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
  endtask

  task automatic addr_end(input logic [15:0] addr);
    @(posedge i_sys_clk);
    o_strobe <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    // Released lines show the inverse, so a stale address cannot pass
    if (LOWER_SHARED) begin
      o_lower <= ~addr[7:0];
    end
    if (UPPER_SHARED) begin
      o_upper <= ~addr[15:8];
    end
  endtask

  task automatic strobes(input logic [2:0] ctl);
    @(posedge i_sys_clk);
    {o_c2, o_c1, o_c0} <= ctl;
  endtask
endmodule // mbfe_mcu_model

`default_nettype wire

// [tb_mcu_bus_front_end.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_mcu_bus_front_end;
  import mbfe_pkg::*;
  logic i_sys_clk;
  logic i_rst_n;
  logic i_block_select;
  logic [15:0] i_read_data;
  logic [7:0] mcu_lower;
  logic [7:0] mcu_upper;
  logic mcu_strobe;
  logic mcu_c0;
  logic mcu_c1;
  logic mcu_c2;
  logic [7:0] lower_bus;
  logic [7:0] dev_lower;
  logic dev_lower_oe;
  logic dev_upper_oe;
  logic [15:0] dev_addr;
  mbfe_ctrl_s dev_ctrl;
  logic [7:0] alt_lower;
  logic [7:0] alt_upper;
  logic alt_strobe;
  logic alt_c0;
  logic alt_c1;
  logic alt_c2;
  logic [7:0] alt_lower_bus;
  logic [7:0] alt_upper_bus;
  logic [7:0] alt_dev_lower;
  logic [7:0] alt_dev_upper;
  logic alt_lower_oe;
  logic alt_upper_oe;
  logic [15:0] alt_addr;
  mbfe_ctrl_s alt_ctrl;
  logic nm_lower_oe;
  logic nm_upper_oe;
  logic [15:0] nm_addr;
  mbfe_ctrl_s nm_ctrl;
  int fails;
  int n_checks;

  assign lower_bus = dev_lower_oe ? dev_lower : mcu_lower;

  mbfe_mcu_model mcu_u (.i_sys_clk(i_sys_clk), .o_lower(mcu_lower), .o_upper(mcu_upper),
    .o_strobe(mcu_strobe), .o_c0(mcu_c0), .o_c1(mcu_c1), .o_c2(mcu_c2));

  mbfe_front_end dut_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_lower_addr_data_port(lower_bus), .i_upper_addr_data_port(mcu_upper),
    .i_address_strobe(mcu_strobe), .i_control_input_0(mcu_c0),
    .i_control_input_1(mcu_c1), .i_control_input_2(mcu_c2),
    .i_block_select(i_block_select), .i_read_data(i_read_data),
    .o_lower_addr_data_port(dev_lower), .o_lower_addr_data_oe(dev_lower_oe),
    .o_upper_addr_data_port(), .o_upper_addr_data_oe(dev_upper_oe),
    .o_latched_addr(dev_addr), .o_pld_ctrl(dev_ctrl));

  // Burst style with a direction line, data strobe and generic third input
  assign alt_lower_bus = alt_lower_oe ? alt_dev_lower : alt_lower;
  assign alt_upper_bus = alt_upper_oe ? alt_dev_upper : alt_upper;

  mbfe_mcu_model #(.STYLE(MBFE_STYLE_BURST)) mcu_alt_u (.i_sys_clk(i_sys_clk),
    .o_lower(alt_lower), .o_upper(alt_upper), .o_strobe(alt_strobe), .o_c0(alt_c0),
    .o_c1(alt_c1), .o_c2(alt_c2));

  mbfe_front_end #(.STYLE(MBFE_STYLE_BURST), .C0_MODE(MBFE_C0_READ_WRITE_N),
      .C1_MODE(MBFE_C1_DATA_STROBE_N), .C2_MODE(MBFE_C2_GENERIC)) dut_alt_u (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_lower_addr_data_port(alt_lower_bus), .i_upper_addr_data_port(alt_upper_bus),
    .i_address_strobe(alt_strobe), .i_control_input_0(alt_c0),
    .i_control_input_1(alt_c1), .i_control_input_2(alt_c2),
    .i_block_select(i_block_select), .i_read_data(i_read_data),
    .o_lower_addr_data_port(alt_dev_lower), .o_lower_addr_data_oe(alt_lower_oe),
    .o_upper_addr_data_port(alt_dev_upper), .o_upper_addr_data_oe(alt_upper_oe),
    .o_latched_addr(alt_addr), .o_pld_ctrl(alt_ctrl));

  // Plain address style, fetch strobe read on the second input and code fetch on the third, watching the same pins
  mbfe_front_end #(.STYLE(MBFE_STYLE_NONMUX), .C1_MODE(MBFE_C1_FETCH_READ_N)) dut_nm_u (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_lower_addr_data_port(mcu_lower), .i_upper_addr_data_port(mcu_upper),
    .i_address_strobe(mcu_strobe), .i_control_input_0(mcu_c0),
    .i_control_input_1(mcu_c1), .i_control_input_2(mcu_c2),
    .i_block_select(i_block_select), .i_read_data(i_read_data),
    .o_lower_addr_data_port(), .o_lower_addr_data_oe(nm_lower_oe),
    .o_upper_addr_data_port(), .o_upper_addr_data_oe(nm_upper_oe),
    .o_latched_addr(nm_addr), .o_pld_ctrl(nm_ctrl));

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Access steps and scenarios
  // ----------------------------------------
  task automatic start_access(input logic [15:0] addr, input logic [2:0] ctl,
      input logic sel, input logic [15:0] rdata);
    mcu_u.addr_phase(addr);
    #1;
    chk_word("latched_addr", addr, dev_addr);
    mcu_u.addr_end(addr);
    i_block_select <= sel;
    i_read_data <= rdata;
    mcu_u.strobes(ctl);
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk_word("held_addr", addr, dev_addr);
    chk_word("nm_addr", {addr[15:8], ~addr[7:0]}, nm_addr);
    chk_word("raw_ctrl", {13'h0000, ctl}, {13'h0000, dev_ctrl.raw});
  endtask

  task automatic end_access;
    mcu_u.strobes(3'h7);
    i_block_select <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk_bit("lower_oe_idle", 1'b0, dev_lower_oe);
    chk_bit("read_idle", 1'b0, dev_ctrl.read);
  endtask

  task automatic sel_read_test;
    start_access(16'h5ac3, 3'h5, 1'b1, 16'h3c96);
    chk_bit("read", 1'b1, dev_ctrl.read);
    chk_bit("write", 1'b0, dev_ctrl.write);
    chk_bit("lower_oe", 1'b1, dev_lower_oe);
    chk_bit("upper_oe", 1'b0, dev_upper_oe);
    chk_word("lower_data", 16'h0096, {8'h00, dev_lower});
    chk_bit("nm_read", 1'b1, nm_ctrl.read);
    chk_word("nm_oe", 16'h0000, {14'h0000, nm_lower_oe, nm_upper_oe});
    end_access;
  endtask

  task automatic unsel_read_test;
    start_access(16'ha53c, 3'h5, 1'b0, 16'h1234);
    chk_bit("read", 1'b1, dev_ctrl.read);
    chk_bit("lower_oe", 1'b0, dev_lower_oe);
    end_access;
  endtask

  task automatic write_test;
    start_access(16'h0ff0, 3'h6, 1'b1, 16'h00ff);
    chk_bit("write", 1'b1, dev_ctrl.write);
    chk_bit("read", 1'b0, dev_ctrl.read);
    chk_bit("lower_oe", 1'b0, dev_lower_oe);
    chk_bit("nm_read", 1'b0, nm_ctrl.read);
    end_access;
  endtask

  task automatic fetch_test;
    start_access(16'hffff, 3'h3, 1'b1, 16'h00a5);
    chk_bit("code_fetch", 1'b1, dev_ctrl.code_fetch);
    chk_bit("lower_oe", 1'b1, dev_lower_oe);
    chk_word("lower_data", 16'h00a5, {8'h00, dev_lower});
    end_access;
  endtask

  task automatic burst_dir_test;
    mcu_alt_u.addr_phase(16'hc35a);
    mcu_alt_u.addr_end(16'hc35a);
    i_block_select <= 1'b1;
    i_read_data <= 16'h69e1;
    mcu_alt_u.strobes(3'h5);
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk_word("alt_addr", 16'hc35a, alt_addr);
    chk_bit("alt_read", 1'b1, alt_ctrl.read);
    chk_bit("alt_generic", 1'b1, alt_ctrl.generic_in);
    chk_word("alt_oe", 16'h0101, {7'h00, alt_lower_oe, 7'h00, alt_upper_oe});
    chk_word("alt_data", 16'h69e1, {alt_dev_upper, alt_dev_lower});
    mcu_alt_u.strobes(3'h0);
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk_bit("alt_write", 1'b1, alt_ctrl.write);
    chk_bit("alt_wr_read", 1'b0, alt_ctrl.read);
    chk_bit("alt_fetch", 1'b0, alt_ctrl.code_fetch);
    chk_word("alt_wr_oe", 16'h0000, {7'h00, alt_lower_oe, 7'h00, alt_upper_oe});
    mcu_alt_u.strobes(3'h7);
    i_block_select <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
  endtask

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    i_rst_n = 1'b0;
    i_block_select = 1'b0;
    i_read_data = 16'h0000;
    fails = 0;
    n_checks = 0;
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    sel_read_test;
    unsel_read_test;
    write_test;
    fetch_test;
    burst_dir_test;
    summarize;
  end
endmodule // tb_mcu_bus_front_end

`default_nettype wire
